// ---- common/sleep_wake_consts.svh ----
// Constants for the sleep, wake and watchdog controller
// What this block does
// - Wake by reset pin, brown-out or power-on reset does a full device reset.
// - Watchdog, external or sleep-capable peripheral interrupt wake resumes without reset.
// - Interrupt wakes only if its own enable set; global enable does not matter.
// - During sleep instruction the next address PC+1 is prefetched.
// - Global disabled: continue inline; enabled: run next instruction, then service routine.
// - Interrupt wake with global enable vectors to the fixed interrupt address.
// - Watchdog counter clears on every wake from sleep.
// - Pending enabled interrupt before sleep with global off: sleep is a no-op.
// - Interrupt during sleep: finish, wake at once, clear watchdog, update flags.
// - Crystal modes without two-speed start-up wake after 1024 oscillator periods; other cases skip it.
// - Regulator power mode bit set puts regulator in low power during sleep.
// - Waking from low-power sleep adds a stabilisation delay.
// - Active low-power-incompatible peripheral keeps regulator normal in sleep.
// - Regulator control bit 0 resets to one and always reads one.
// - Watchdog resets the device if not cleared within the time-out.
// - Watchdog counts the 31 kHz low-frequency oscillator, 1 ms base.
// - Time-out selectable from 1 ms to 256 seconds.
// - Mode 11: watchdog always active, including sleep.
// - Mode 10: active while awake, inactive in sleep.
// - Mode 01: watchdog follows software enable, sleep does not change it.
// - Software enable honoured only in mode 01.
// - Watchdog time-out in sleep wakes the device instead of resetting it.
// - Period select resets to the two-second setting.
// - Sleep instruction clears power-down flag and sets time-out flag.
`ifndef SLEEP_WAKE_CONSTS_SVH
`define SLEEP_WAKE_CONSTS_SVH
`define ADDR_REG_CTRL     8'h00
`define ADDR_CORE_STATUS  8'h01
`define ADDR_WDOG_CTRL    8'h02
`define ADDR_WAKE_STATE   8'h03
`define REG_CTRL_RESET    8'h01
`define REG_CTRL_PM_BIT   1
`define REG_CTRL_RSV_BIT  0
`define WDOG_CTRL_RESET   8'h16
`define WDOG_EN_BIT       0
`define WDOG_PS_LSB       1
`define WDOG_PS_MSB       5
`define WDOG_PS_MAXSEL    5'h12
`define WDOG_PS_BASE      6'h05
`define STAT_TO_BIT       4
`define STAT_PD_BIT       3
`define STATUS_RESET      8'h18
`define ISR_VECTOR        15'h0004
`define OST_PERIODS       11'h0400
`define LP_STAB_NS        32'd0000_5000
`define CLK_PERIOD_NS     32'd0000_0040
`define MODE_ALWAYS       2'h3
`define MODE_AWAKE        2'h2
`define MODE_SOFT         2'h1
`endif

// ---- common/sleep_wake_pkg.sv ----
// Types for the sleep, wake and watchdog controller
package sleep_wake_pkg;
    typedef enum logic [4:0] {
        ST_RUN    = 5'b0_0001,
        ST_SLEEP  = 5'b0_0010,
        ST_OST    = 5'b0_0100,
        ST_STAB   = 5'b0_1000,
        ST_RESUME = 5'b1_0000
    } pwr_state_e;
    typedef enum logic [2:0] {
        OSC_LP = 3'h0, OSC_XT = 3'h1, OSC_HS = 3'h2, OSC_EXTRC = 3'h3,
        OSC_INTERNAL_OSC_MODE = 3'h4, OSC_ECL = 3'h5, OSC_ECM = 3'h6, OSC_ECH = 3'h7
    } osc_mode_e;
    typedef struct packed {
        logic        resume;
        logic        vector_isr;
        logic [14:0] pc;
    } core_resume_s;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;
endpackage

// ---- hdl/sleep_wake_watchdog_control.sv ----
// Sleep entry, wake sorting, status flags, regulator mode and watchdog
`include "sleep_wake_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_watchdog_control (
    input  wire logic                         i_clk,
    input  wire logic                         i_rst_n,
    input  wire sleep_wake_pkg::reg_req_s     i_reg,
    output logic     [7:0]                    o_rdata,
    input  wire logic [1:0]                   i_watchdog_mode_config,
    input  wire sleep_wake_pkg::osc_mode_e    i_osc_mode,
    input  wire logic                         i_two_speed_startup,
    input  wire logic                         i_external_reset_pin_n,
    input  wire logic                         i_external_reset_pin_en,
    input  wire logic                         i_brownout_reset,
    input  wire logic                         i_brownout_reset_en,
    input  wire logic                         i_power_on_reset,
    input  wire logic                         i_sleep_exec,
    input  wire logic                         i_watchdog_clear_instruction,
    input  wire logic [14:0]                  i_pc,
    input  wire logic                         i_global_interrupt_enable,
    input  wire logic [7:0]                   i_int_flags,
    input  wire logic [7:0]                   i_int_enables,
    input  wire logic                         i_lp_incompatible_active,
    input  wire logic                         i_lfosc_tick,
    input  wire logic                         i_osc_tick,
    output logic                              o_device_reset,
    output logic                              o_cpu_clk_en,
    output logic                              o_sleeping,
    output logic     [14:0]                   o_prefetch_addr,
    output sleep_wake_pkg::core_resume_s      o_resume,
    output logic                              o_regulator_low_power
);
    // Software state
    logic [7:0] reg_ctrl_reg, reg_ctrl_next;
    logic [7:0] status_reg, status_next;
    logic [7:0] wdog_ctrl_reg, wdog_ctrl_next;
    logic [7:0] rdata_reg, rdata_next;
    // Power state
    sleep_wake_pkg::pwr_state_e state_reg, state_next;
    logic [10:0] ost_cnt_reg, ost_cnt_next;
    logic [15:0] stab_cnt_reg, stab_cnt_next;
    logic        lp_slept_reg, lp_slept_next;
    logic        isr_pend_reg, isr_pend_next;
    logic [14:0] pref_reg, pref_next;
    logic        dev_rst_reg, dev_rst_next;
    sleep_wake_pkg::core_resume_s resume_reg, resume_next;
    // Watchdog
    logic [23:0] wdog_cnt_reg, wdog_cnt_next;

    localparam logic [15:0] STAB_CYCLES =
        16'((`LP_STAB_NS + `CLK_PERIOD_NS - 32'd1) / `CLK_PERIOD_NS);

    logic       hw_reset_req;
    logic       int_pending;
    logic       wdog_active;
    logic       wdog_timeout;
    logic [4:0] ps_sel;
    logic [4:0] ps_eff;
    logic [23:0] wdog_limit;
    logic       osc_needs_ost;
    logic       wake_event;
    logic       enter_sleep;
    logic [7:0] pend_vec;

    // Reset sources bypass sleep entirely
    assign hw_reset_req = (i_external_reset_pin_en & ~i_external_reset_pin_n)
                        | (i_brownout_reset_en & i_brownout_reset)
                        | i_power_on_reset;

    // Per-source enable gating, global enable deliberately ignored
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : gen_pend
            assign pend_vec[g] = i_int_flags[g] & i_int_enables[g];
        end
    endgenerate
    assign int_pending = |pend_vec;

    // Watchdog mode decode
    always_comb begin
        case (i_watchdog_mode_config)
            `MODE_ALWAYS: wdog_active = 1'b1;
            `MODE_AWAKE:  wdog_active = (state_reg == sleep_wake_pkg::ST_RUN);
            `MODE_SOFT:   wdog_active = wdog_ctrl_reg[`WDOG_EN_BIT];
            default:      wdog_active = 1'b0;
        endcase
    end

    // Reserved selects fall back to minimum interval
    assign ps_sel = wdog_ctrl_reg[`WDOG_PS_MSB:`WDOG_PS_LSB];
    assign ps_eff = (ps_sel > `WDOG_PS_MAXSEL) ? 5'h00 : ps_sel;
    // 1:32 of the 31 kHz tick is the 1 ms base interval
    assign wdog_limit = 24'(24'h00_0001 << (6'(ps_eff) + `WDOG_PS_BASE));
    assign wdog_timeout = wdog_active && (wdog_cnt_reg >= wdog_limit - 24'h00_0001)
                          && i_lfosc_tick;

    assign osc_needs_ost = (i_osc_mode == sleep_wake_pkg::OSC_LP
                         || i_osc_mode == sleep_wake_pkg::OSC_XT
                         || i_osc_mode == sleep_wake_pkg::OSC_HS)
                         && !i_two_speed_startup;

    assign enter_sleep = (state_reg == sleep_wake_pkg::ST_RUN) && i_sleep_exec;
    assign wake_event  = int_pending || wdog_timeout;

    // Power sequencing next state
    always_comb begin
        state_next    = state_reg;
        ost_cnt_next  = ost_cnt_reg;
        stab_cnt_next = stab_cnt_reg;
        lp_slept_next = lp_slept_reg;
        isr_pend_next = isr_pend_reg;
        pref_next     = pref_reg;
        resume_next   = '0;
        case (state_reg)
            sleep_wake_pkg::ST_RUN: begin
                // Pending enabled interrupt with global off makes sleep a no-op
                if (enter_sleep && !(int_pending && !i_global_interrupt_enable)) begin
                    pref_next = 15'(i_pc + 15'h0001);
                    lp_slept_next = reg_ctrl_reg[`REG_CTRL_PM_BIT] && !i_lp_incompatible_active;
                    state_next = sleep_wake_pkg::ST_SLEEP;
                end
            end
            sleep_wake_pkg::ST_SLEEP: begin
                // Races during the instruction wake at once here
                if (wake_event) begin
                    isr_pend_next = int_pending && i_global_interrupt_enable;
                    ost_cnt_next  = '0;
                    stab_cnt_next = '0;
                    if (osc_needs_ost) begin
                        state_next = sleep_wake_pkg::ST_OST;
                    end else if (lp_slept_reg) begin
                        state_next = sleep_wake_pkg::ST_STAB;
                    end else begin
                        state_next = sleep_wake_pkg::ST_RESUME;
                    end
                end
            end
            sleep_wake_pkg::ST_OST: begin
                if (i_osc_tick) begin
                    ost_cnt_next = 11'(ost_cnt_reg + 11'h001);
                end
                if (ost_cnt_reg == `OST_PERIODS) begin
                    state_next = lp_slept_reg ? sleep_wake_pkg::ST_STAB
                                              : sleep_wake_pkg::ST_RESUME;
                end
            end
            sleep_wake_pkg::ST_STAB: begin
                // Regulator settling before core restarts
                stab_cnt_next = 16'(stab_cnt_reg + 16'h0001);
                if (stab_cnt_reg >= STAB_CYCLES - 16'h0001) begin
                    state_next = sleep_wake_pkg::ST_RESUME;
                end
            end
            sleep_wake_pkg::ST_RESUME: begin
                // Prefetched instruction runs first, then the vector
                resume_next.resume     = 1'b1;
                resume_next.vector_isr = isr_pend_reg;
                resume_next.pc         = isr_pend_reg ? `ISR_VECTOR : pref_reg;
                lp_slept_next = 1'b0;
                isr_pend_next = 1'b0;
                state_next    = sleep_wake_pkg::ST_RUN;
            end
            default: state_next = sleep_wake_pkg::ST_RUN;
        endcase
    end

    // Watchdog counter; held clear from the wake event through start-up and settling
    always_comb begin
        wdog_cnt_next = wdog_cnt_reg;
        dev_rst_next  = hw_reset_req;
        if (!wdog_active || i_watchdog_clear_instruction
            || (enter_sleep && state_next == sleep_wake_pkg::ST_SLEEP)
            || state_reg == sleep_wake_pkg::ST_OST
            || state_reg == sleep_wake_pkg::ST_STAB // Settling must not trip a reset
            || (state_reg == sleep_wake_pkg::ST_SLEEP && wake_event)) begin
            wdog_cnt_next = '0;
        end else if (wdog_timeout) begin
            wdog_cnt_next = '0;
            // Timeout while awake resets; in sleep it only wakes
            if (state_reg != sleep_wake_pkg::ST_SLEEP) begin
                dev_rst_next = 1'b1;
            end
        end else if (i_lfosc_tick) begin
            wdog_cnt_next = 24'(wdog_cnt_reg + 24'h00_0001);
        end
    end

    // Register writes and status flag updates
    always_comb begin
        reg_ctrl_next  = reg_ctrl_reg;
        status_next    = status_reg;
        wdog_ctrl_next = wdog_ctrl_reg;
        rdata_next     = 8'h00;
        if (i_reg.wr) begin
            case (i_reg.addr)
                `ADDR_REG_CTRL: begin
                    reg_ctrl_next = {6'h00, i_reg.wdata[`REG_CTRL_PM_BIT], 1'b1};
                end
                `ADDR_WDOG_CTRL: wdog_ctrl_next = {2'h0, i_reg.wdata[5:0]};
                default: ;
            endcase
        end
        // Flags are hardware-owned; sleep entry sets them last
        if (enter_sleep && state_next == sleep_wake_pkg::ST_SLEEP) begin
            status_next[`STAT_PD_BIT] = 1'b0;
            status_next[`STAT_TO_BIT] = 1'b1;
        end
        // Watchdog wake from sleep marks time-out
        if (state_reg == sleep_wake_pkg::ST_SLEEP && wdog_timeout && !int_pending) begin
            status_next[`STAT_TO_BIT] = 1'b0;
        end
        if (i_reg.rd) begin
            case (i_reg.addr)
                `ADDR_REG_CTRL:    rdata_next = reg_ctrl_reg | 8'h01;
                `ADDR_CORE_STATUS: rdata_next = status_reg;
                `ADDR_WDOG_CTRL:   rdata_next = wdog_ctrl_reg;
                `ADDR_WAKE_STATE:  rdata_next = {3'h0, state_reg};
                default:           rdata_next = 8'h00;
            endcase
        end
    end

    // Register all state
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_reg     <= sleep_wake_pkg::ST_RUN;
            ost_cnt_reg   <= '0;
            stab_cnt_reg  <= '0;
            lp_slept_reg  <= 1'b0;
            isr_pend_reg  <= 1'b0;
            pref_reg      <= '0;
            resume_reg    <= '0;
            dev_rst_reg   <= 1'b0;
            wdog_cnt_reg  <= '0;
            reg_ctrl_reg  <= `REG_CTRL_RESET;
            status_reg    <= `STATUS_RESET;
            wdog_ctrl_reg <= `WDOG_CTRL_RESET;
            rdata_reg     <= 8'h00;
        end else begin
            state_reg     <= state_next;
            ost_cnt_reg   <= ost_cnt_next;
            stab_cnt_reg  <= stab_cnt_next;
            lp_slept_reg  <= lp_slept_next;
            isr_pend_reg  <= isr_pend_next;
            pref_reg      <= pref_next;
            resume_reg    <= resume_next;
            dev_rst_reg   <= dev_rst_next;
            wdog_cnt_reg  <= wdog_cnt_next;
            reg_ctrl_reg  <= reg_ctrl_next;
            status_reg    <= status_next;
            wdog_ctrl_reg <= wdog_ctrl_next;
            rdata_reg     <= rdata_next;
        end
    end

    // Outputs
    assign o_rdata         = rdata_reg;
    assign o_device_reset  = dev_rst_reg;
    assign o_cpu_clk_en    = (state_reg == sleep_wake_pkg::ST_RUN);
    assign o_sleeping      = (state_reg == sleep_wake_pkg::ST_SLEEP);
    assign o_prefetch_addr = pref_reg;
    assign o_resume        = resume_reg;
    // Incompatible peripheral overrides low power
    assign o_regulator_low_power = o_sleeping && lp_slept_reg
                                   && !i_lp_incompatible_active;
endmodule
`default_nettype wire

// ---- tb/tick_source_model.sv ----
// Oscillator tick source standing in for the clock side of the core
`timescale 1ns/1ps
`default_nettype none
module tick_source_model #(
    parameter int LF_DIV = 2
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    output logic      o_lf_tick = 1'b0,
    output logic      o_osc_tick = 1'b0
);
    int cnt = 0;
    // Slow tick every LF_DIV cycles; shortened so time-outs fit the run
    always @(posedge i_clk) begin
        cnt <= (!i_rst_n || cnt == LF_DIV - 1) ? 0 : cnt + 1;
        o_lf_tick <= i_rst_n && cnt == LF_DIV - 1;
        o_osc_tick <= i_rst_n;
    end
endmodule
`default_nettype wire

// ---- tb/swwc_properties.sv ----
// Port-level checks for the sleep, wake and watchdog controller
`timescale 1ns/1ps
`default_nettype none
module swwc_properties (
    input wire logic                         i_clk,
    input wire logic                         i_rst_n,
    input wire sleep_wake_pkg::reg_req_s     i_reg,
    input wire logic [7:0]                   o_rdata,
    input wire logic                         i_sleep_exec,
    input wire logic [14:0]                  i_pc,
    input wire logic                         i_global_interrupt_enable,
    input wire logic [7:0]                   i_int_flags,
    input wire logic [7:0]                   i_int_enables,
    input wire logic                         i_lp_incompatible_active,
    input wire logic                         o_cpu_clk_en,
    input wire logic                         o_sleeping,
    input wire logic [14:0]                  o_prefetch_addr,
    input wire sleep_wake_pkg::core_resume_s o_resume,
    input wire logic                         o_regulator_low_power
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    logic pend;
    // Any enabled interrupt pending, whatever the global enable says
    assign pend = |(i_int_flags & i_int_enables);
    // Honoured sleep request, and the exit from low-power sleep
    sequence s_take;
        i_sleep_exec && o_cpu_clk_en && !(pend && !i_global_interrupt_enable);
    endsequence
    sequence s_lp_exit;
        $fell(o_sleeping) && $past(o_regulator_low_power);
    endsequence
    property p_take;
        s_take |=> o_sleeping && o_prefetch_addr == $past(i_pc) + 15'h0001;
    endproperty
    a_take: assert property (p_take) else $error("sleep entry wrong");
    property p_nop;
        i_sleep_exec && o_cpu_clk_en && pend && !i_global_interrupt_enable |=> !o_sleeping;
    endproperty
    a_nop: assert property (p_nop) else $error("sleep not skipped");
    property p_int_wake;
        o_sleeping && pend |=> !o_sleeping;
    endproperty
    a_int_wake: assert property (p_int_wake) else $error("no wake");
    property p_vector;
        o_resume.resume && o_resume.vector_isr |-> o_resume.pc == 15'h0004;
    endproperty
    a_vector: assert property (p_vector) else $error("bad vector");
    property p_inline;
        o_resume.resume && !o_resume.vector_isr |-> o_resume.pc == o_prefetch_addr;
    endproperty
    a_inline: assert property (p_inline) else $error("bad resume address");
    property p_reserved;
        i_reg.rd && i_reg.addr == 8'h00 |=> o_rdata[0] && o_rdata[7:2] == 6'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("bad reserved bit");
    property p_lp_stab;
        s_lp_exit |-> !o_resume.resume [*8];
    endproperty
    a_lp_stab: assert property (p_lp_stab) else $error("resumed too early");
    property p_lp_block;
        i_lp_incompatible_active && $past(i_lp_incompatible_active) |-> !o_regulator_low_power;
    endproperty
    a_lp_block: assert property (p_lp_block) else $error("regulator low");
endmodule
bind sleep_wake_watchdog_control swwc_properties u_props (.*);
`default_nettype wire

// ---- tb/sleep_wake_watchdog_control_bench.sv ----
// Self-checking bench for the sleep, wake and watchdog controller
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_watchdog_control_bench;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_sleep_exec = 1'b0, i_power_on_reset = 1'b0;
    logic i_two_speed_startup = 1'b0, i_external_reset_pin_n = 1'b1, i_brownout_reset = 1'b0;
    logic i_external_reset_pin_en = 1'b1, i_brownout_reset_en = 1'b1;
    logic i_watchdog_clear_instruction = 1'b0, i_global_interrupt_enable = 1'b0;
    logic i_lp_incompatible_active = 1'b0, i_lfosc_tick, i_osc_tick;
    logic [1:0] i_watchdog_mode_config = 2'h0;
    logic [7:0] i_int_flags = 8'h00, i_int_enables = 8'h00, o_rdata;
    logic [14:0] i_pc = 15'h0000, o_prefetch_addr;
    sleep_wake_pkg::reg_req_s i_reg = '0;
    sleep_wake_pkg::osc_mode_e i_osc_mode = sleep_wake_pkg::OSC_INTERNAL_OSC_MODE;
    sleep_wake_pkg::core_resume_s o_resume;
    logic o_device_reset, o_cpu_clk_en, o_sleeping, o_regulator_low_power;
    int fail_count = 0, num_checks = 0, n_rst = 0, k;
    sleep_wake_watchdog_control uut (.*);
    tick_source_model #(.LF_DIV(2)) u_ticks (
        .i_clk, .i_rst_n, .o_lf_tick(i_lfosc_tick), .o_osc_tick(i_osc_tick));
    // Clock, and a count of device reset pulses
    always #20 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        if (o_device_reset === 1'b1) n_rst <= n_rst + 1;
    end
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One register cycle; for a read d is the expected data
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        i_reg <= '{addr: a, wdata: w ? d : 8'h00, wr: w, rd: !w};
        @(posedge i_clk);
        i_reg <= '0;
        #1;
        if (!w) chk(o_rdata, d);
        @(posedge i_clk);
    endtask
    // Start-up wait plus regulator settling expected after a wake
    function automatic int wake_floor(input logic [2:0] m, input logic t, input logic i);
        return ((m < 3'h3 && !t) ? 1024 : 0) + (i ? 0 : 125);
    endfunction
    // Bounded wait for the resume pulse; a hang ends the run
    task automatic wait_resume(output int n);
        n = 0;
        do begin
            @(posedge i_clk);
            #1 n++;
            if (n > 2000) begin
                fail_count++;
                report_and_stop();
            end
        end while (o_resume.resume !== 1'b1);
    endtask
    // Sleep, then wake by interrupt or, in always-on mode, by time-out
    task automatic nap(input logic g, input logic [2:0] m, input logic [1:0] wm,
                       input logic [7:0] st);
        int n;
        int lo;
        logic [14:0] p;
        logic [7:0] b;
        p = 15'($urandom);
        b = 8'h01 << $urandom_range(7, 0);
        k = n_rst;
        i_global_interrupt_enable <= g;
        i_osc_mode <= sleep_wake_pkg::osc_mode_e'(m);
        i_watchdog_mode_config <= wm;
        i_two_speed_startup <= 1'($urandom);
        i_lp_incompatible_active <= 1'($urandom);
        i_pc <= p;
        i_sleep_exec <= 1'b1;
        @(posedge i_clk);
        i_sleep_exec <= 1'b0;
        lo = wake_floor(m, i_two_speed_startup, i_lp_incompatible_active);
        if (wm != 2'h3) begin
            i_int_flags <= b;
            repeat (150) @(posedge i_clk);
            bus(1'b0, 8'h03, 8'h02);
            @(negedge i_clk);
            chk(o_regulator_low_power, !i_lp_incompatible_active);
            @(posedge i_clk);
            i_int_enables <= b;
        end
        wait_resume(n);
        chk(n >= lo && n <= lo + 100, 1'b1);
        chk(o_resume.pc, (g && wm != 2'h3) ? 15'h0004 : 15'(p + 15'h0001));
        chk(n_rst - k, 0);
        @(posedge i_clk);
        i_watchdog_mode_config <= 2'h0;
        i_int_flags <= 8'h00;
        i_int_enables <= 8'h00;
        bus(1'b0, 8'h01, st);
    endtask
    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Main sequence: reset values, skipped sleep, wakes, reset sources, watchdog
    initial begin
        void'($urandom(32'h5925_fd02));
        repeat (10) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        bus(1'b0, 8'h00, 8'h01);
        bus(1'b0, 8'h02, 8'h16);
        bus(1'b0, 8'h05, 8'h00);
        bus(1'b1, 8'h01, 8'h00);
        bus(1'b0, 8'h01, 8'h18);
        i_int_flags <= 8'h80;
        i_int_enables <= 8'h80;
        i_sleep_exec <= 1'b1;
        @(posedge i_clk);
        i_sleep_exec <= 1'b0;
        i_int_flags <= 8'h00;
        i_int_enables <= 8'h00;
        bus(1'b0, 8'h03, 8'h01);
        bus(1'b0, 8'h01, 8'h18);
        bus(1'b1, 8'h00, 8'h02);
        bus(1'b0, 8'h00, 8'h03);
        bus(1'b1, 8'h02, 8'h00);
        for (int m = 0; m < 8; m++) begin
            nap(1'($urandom), 3'(m), {m[0], 1'b0}, 8'h10);
        end
        nap(1'b0, 3'h4, 2'h3, 8'h00);
        for (int s = 0; s < 3; s++) begin
            k = n_rst;
            i_power_on_reset <= (s == 0);
            i_brownout_reset <= (s == 1);
            i_external_reset_pin_n <= (s != 2);
            @(posedge i_clk);
            i_power_on_reset <= 1'b0;
            i_brownout_reset <= 1'b0;
            i_external_reset_pin_n <= 1'b1;
            repeat (2) @(posedge i_clk);
            chk(n_rst - k, 1);
        end
        k = n_rst;
        bus(1'b1, 8'h02, 8'h01);
        repeat (200) @(posedge i_clk);
        chk(n_rst - k, 0);
        i_watchdog_mode_config <= 2'h1;
        repeat (6) begin
            i_watchdog_clear_instruction <= 1'b1;
            @(posedge i_clk);
            i_watchdog_clear_instruction <= 1'b0;
            repeat (19) @(posedge i_clk);
        end
        chk(n_rst - k, 0);
        repeat (100) @(posedge i_clk);
        chk(n_rst - k > 0, 1'b1);
        report_and_stop();
    end
endmodule
`default_nettype wire
